// ---- include/status_led_defines.svh ----
// timing and register constants for the status indicator driver
// assumes a 250 MHz system clock and a 32-bit APB register bus
`ifndef STATUS_LED_DEFINES_SVH
`define STATUS_LED_DEFINES_SVH

`define CLK_MHZ          250
`define MS_CYCLES        (`CLK_MHZ * 1000)
`define LAMP_TEST_MS     500
`define LAMP_STEP_MS     100
`define LIT_MS           200
`define GAP_MS           200
`define PAUSE_MS         1000

`define REG_CTRL         12'h000
`define REG_STATUS       12'h004
`define REG_NODE         12'h008

`define CTRL_ENABLE_BIT  0
`define CTRL_RESET       32'h0000_0001
`define NODE_RESET       7'h01
`define NODE_MIN         7'h01
`define NODE_MAX         7'h7F

`endif

// ---- include/status_led_pkg.sv ----
// types for the status indicator driver
// assumes nothing beyond the defines header
package status_led_pkg;
	typedef enum logic [1:0] {PAT_OFF, PAT_BLINK, PAT_SINGLE, PAT_DOUBLE} pat_e;
	typedef enum logic [1:0] {NMT_INIT, NMT_STOPPED, NMT_PREOP, NMT_OPER} nmt_e;
endpackage : status_led_pkg

// ---- sim/led_run_observer.sv ----
// operator's view of one indicator: length of each finished lit/dark run
// assumes the led pin is a registered level on sys_clk, high = lit
`timescale 1ns/10ps

module led_run_observer (
	// clock
	input  wire logic sys_clk,
	// watched indicator
	input  wire logic led,
	// last finished run, in clock cycles, and a toggle on each new run
	output int        runLen,
	output logic      flip
);
	int   count = 0;
	logic last  = 1'b0;

	initial begin
		runLen = 0;
		flip   = 1'b0;
	end

	// the eye only sees edges; a level change closes the run
	always @(posedge sys_clk) begin
		if (led !== last) begin
			runLen <= count;
			count  <= 1;
			flip   <= ~flip;
		end else begin
			count <= count + 1;
		end
		last <= led;
	end
endmodule : led_run_observer

// ---- sim/test_canopen_status_led_driver.sv ----
// self-checking bench for the CAN status indicator driver
// assumes the driver and an operator model on each indicator pin
`timescale 1ns/10ps

module test_canopen_status_led_driver;
	localparam int MS = 5;
	logic        sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, redLed, greenLed, flipR, flipG;
	logic        warnLevel = 0, errPassive = 0, guardTimeout = 0;
	logic        errCtrlStarted = 0, busOff = 0, canPowered = 1;
	logic [1:0]  nmtState = 2'h0;
	logic [6:0]  nodeId;
	int          runR, runG, err_total = 0, checks = 0;

	always #2 sys_clk = ~sys_clk;

	canopen_status_led_driver #(.MS_CYCLES(MS)) dut (.sys_clk(sys_clk),
		.rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .warnLevel(warnLevel), .errPassive(errPassive),
		.guardTimeout(guardTimeout), .errCtrlStarted(errCtrlStarted),
		.busOff(busOff), .nmtState(nmtState), .canPowered(canPowered),
		.redLed(redLed), .greenLed(greenLed), .nodeId(nodeId));
	led_run_observer eyeR (.sys_clk(sys_clk), .led(redLed),
		.runLen(runR), .flip(flipR));
	led_run_observer eyeG (.sys_clk(sys_clk), .led(greenLed),
		.runLen(runG), .flip(flipG));

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic check(input string nm, input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			finish_test();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	// one finished run of the chosen indicator
	task automatic next_run(input bit red, output int len);
		logic t0;
		int   n;
		t0 = red ? flipR : flipG;
		n  = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while ((red ? flipR : flipG) === t0 && n < 7000);
		if (n >= 7000) begin
			err_total++;
			finish_test();
		end
		len = red ? runR : runG;
	endtask : next_run

	// skips the restart period, then measures lit,dark,lit,dark
	task automatic pat(input bit red, input int lit, input int darkSum);
		int l1, d1, l2, d2, rises;
		rises = 0;
		while (rises < 2) begin
			next_run(red, l1);
			if ((red ? redLed : greenLed) === 1'b1) begin
				rises++;
			end
		end
		next_run(red, l1);
		next_run(red, d1);
		next_run(red, l2);
		next_run(red, d2);
		check("lit run 1", l1, lit);
		check("lit run 2", l2, lit);
		check("dark runs", d1 + d2, darkSum);
	endtask : pat

	task automatic t_lamp;
		repeat (20) @(posedge sys_clk);
		check("lamp red first", redLed, 1);
		check("lamp green first", greenLed, 0);
		repeat (100 * MS) @(posedge sys_clk);
		check("lamp red second", redLed, 0);
		check("lamp green second", greenLed, 1);
		repeat (400 * MS + 200) @(posedge sys_clk);
		check("idle red", redLed, 0);
		check("idle green", greenLed, 0);
	endtask : t_lamp

	task automatic t_regs;
		apb(0, 12'h000, 0);
		check("ctrl reset", rd, 32'h0000_0001);
		apb(0, 12'h008, 0);
		check("node reset", rd, 32'h0000_0001);
		apb(1, 12'h008, 32'h0000_007F);
		check("node max", nodeId, 7'h7F);
		apb(0, 12'h008, 0);
		check("node read", rd, 32'h0000_007F);
		apb(1, 12'h008, 32'h0000_0080);
		check("node over err", er, 1);
		apb(1, 12'h008, 32'h0000_0000);
		check("node zero err", er, 1);
		check("node kept", nodeId, 7'h7F);
		apb(0, 12'h00C, 0);
		check("unmapped err", er, 1);
	endtask : t_regs

	task automatic t_green;
		nmtState <= 2'h3;
		repeat (300 * MS) @(posedge sys_clk);
		check("oper steady", greenLed, 1);
		nmtState <= 2'h2;
		pat(0, 200 * MS, 400 * MS);
		nmtState <= 2'h1;
		pat(0, 200 * MS, 2000 * MS);
	endtask : t_green

	task automatic t_red;
		nmtState  <= 2'h3;
		errPassive <= 1'b1;
		pat(1, 200 * MS, 2000 * MS);
		check("green forced dark", greenLed, 0);
		guardTimeout   <= 1'b1;
		errCtrlStarted <= 1'b1;
		pat(1, 200 * MS, 1200 * MS);
		busOff <= 1'b1;
		repeat (400 * MS) @(posedge sys_clk);
		check("busoff steady", redLed, 1);
		check("green dark busoff", greenLed, 0);
		apb(1, 12'h000, 0);
		repeat (3) @(posedge sys_clk);
		check("disabled red", redLed, 0);
		check("disabled green", greenLed, 0);
	endtask : t_red

	// warning level seen through the status word, then interface power lost
	task automatic t_power;
		apb(1, 12'h000, 32'h0000_0001);
		busOff       <= 1'b0;
		guardTimeout <= 1'b0;
		errPassive   <= 1'b0;
		warnLevel    <= 1'b1;
		repeat (3) @(posedge sys_clk);
		check("warn lit", redLed, 1);
		apb(0, 12'h004, 0);
		check("status warn", rd & 32'h0000_0039, 32'h0000_0038);
		canPowered <= 1'b0;
		repeat (5) @(posedge sys_clk);
		check("unpowered red", redLed, 0);
		check("unpowered green", greenLed, 0);
		apb(0, 12'h004, 0);
		check("status unpowered", rd & 32'h0000_0039, 32'h0000_0020);
	endtask : t_power

	initial begin
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_lamp();
		t_regs();
		t_green();
		t_red();
		t_power();
		finish_test();
	end
endmodule : test_canopen_status_led_driver

// ---- verilog/canopen_status_led_driver.sv ----
// bicolour CAN status indicator driver with APB register slave
// assumes status inputs from controller logic on sys_clk; leds are pins
//
// Summary of operation
// - after reset alternate red and green for about 500 ms
// - blink: lit 200 ms, dark 200 ms, repeated
// - single flash: lit 200 ms, dark 1 s, repeated
// - double flash: two 200 ms pulses 200 ms apart, then 1 s dark
// - red dark without errors, or when disabled or unpowered
// - red single flash at warning level or error passive
// - red double flash on guarding or heartbeat timeout once started
// - red steady on while bus-off
// - green single flash while stopped
// - green blinks while pre-operational
// - green steady on while operational
// - any red indication forces green dark
// - node identifier within 1..127, unique on the network; only the 1..127 range is checked here, uniqueness is not
`timescale 1ns/10ps
`include "status_led_defines.svh"

module canopen_status_led_driver #(
	parameter int MS_CYCLES = `MS_CYCLES
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// status from can controller and slave stack
	input  wire logic        warnLevel,
	input  wire logic        errPassive,
	input  wire logic        guardTimeout,
	input  wire logic        errCtrlStarted,
	input  wire logic        busOff,
	input  wire logic [1:0]  nmtState,
	input  wire logic        canPowered,
	// indicator pins
	output logic             redLed,
	output logic             greenLed,
	// configured node identifier
	output logic      [6:0]  nodeId
);

	if (MS_CYCLES < 2) begin : g_ms_check
		$error("MS_CYCLES too small");
	end

	localparam int CW = $clog2(MS_CYCLES);
	// pattern cycle counted in ms, longest is 200+200+200+1000
	localparam int PW = 11;

	logic [CW-1:0] msCnt;
	logic          msTick;
	logic [PW-1:0] testMs;
	logic          testDone;
	logic          enable;
	logic [1:0]    pwrSync;
	logic          redOn;
	logic          redSteady;
	logic [PW-1:0] redPh;
	logic [PW-1:0] grnPh;
	status_led_pkg::pat_e redPat;
	status_led_pkg::pat_e grnPat;
	status_led_pkg::pat_e redPatQ;
	status_led_pkg::pat_e grnPatQ;
	logic          grnSteady;
	logic          redLit;
	logic          grnLit;
	logic          nodeBad;

	// power flag comes from the isolated side, so synchronise it
	always_ff @(posedge sys_clk) begin
		if (!rst_b) pwrSync <= 2'h0;
		else pwrSync <= {pwrSync[0], canPowered};
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b || msTick) msCnt <= '0;
		else msCnt <= msCnt + 1'b1;
	end
	assign msTick = (msCnt == CW'(MS_CYCLES - 1));

	always_ff @(posedge sys_clk) begin
		if (!rst_b) testMs <= '0;
		else if (msTick && !testDone) testMs <= testMs + 1'b1;
	end
	assign testDone = (testMs == PW'(`LAMP_TEST_MS));

	// red selection, priority order
	always_comb begin
		redPat = status_led_pkg::PAT_OFF;
		redSteady = 1'b0;
		if (!enable || !pwrSync[1]) redPat = status_led_pkg::PAT_OFF;
		else if (busOff) redSteady = 1'b1;
		else if (guardTimeout && errCtrlStarted)
			redPat = status_led_pkg::PAT_DOUBLE;
		else if (warnLevel || errPassive)
			redPat = status_led_pkg::PAT_SINGLE;
	end
	assign redOn = redSteady || (redPat != status_led_pkg::PAT_OFF);

	always_comb begin
		grnPat = status_led_pkg::PAT_OFF;
		grnSteady = 1'b0;
		case (status_led_pkg::nmt_e'(nmtState))
			status_led_pkg::NMT_STOPPED: grnPat = status_led_pkg::PAT_SINGLE;
			status_led_pkg::NMT_PREOP:   grnPat = status_led_pkg::PAT_BLINK;
			status_led_pkg::NMT_OPER:    grnSteady = 1'b1;
			default:                     grnPat = status_led_pkg::PAT_OFF;
		endcase
		if (!enable || !pwrSync[1]) begin
			grnPat = status_led_pkg::PAT_OFF;
			grnSteady = 1'b0;
		end
	end

	function automatic logic [PW-1:0] periodMs(status_led_pkg::pat_e p);
		case (p)
			status_led_pkg::PAT_BLINK:  periodMs = PW'(`LIT_MS + `GAP_MS);
			status_led_pkg::PAT_SINGLE: periodMs = PW'(`LIT_MS + `PAUSE_MS);
			default: periodMs = PW'(2 * `LIT_MS + `GAP_MS + `PAUSE_MS);
		endcase
	endfunction : periodMs

	function automatic logic litAt(status_led_pkg::pat_e p,
		logic [PW-1:0] ph);
		case (p)
			status_led_pkg::PAT_BLINK:  litAt = ph < PW'(`LIT_MS);
			status_led_pkg::PAT_SINGLE: litAt = ph < PW'(`LIT_MS);
			status_led_pkg::PAT_DOUBLE: litAt = (ph < PW'(`LIT_MS)) ||
				(ph >= PW'(`LIT_MS + `GAP_MS) &&
				 ph < PW'(2 * `LIT_MS + `GAP_MS));
			default: litAt = 1'b0;
		endcase
	endfunction : litAt

	// phase counters restart whenever the selection changes
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			redPatQ <= status_led_pkg::PAT_OFF;
			redPh <= '0;
		end else begin
			redPatQ <= redPat;
			if (redPat != redPatQ) redPh <= '0;
			else if (msTick)
				redPh <= (redPh == periodMs(redPat) - 1'b1) ? '0
					: redPh + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			grnPatQ <= status_led_pkg::PAT_OFF;
			grnPh <= '0;
		end else begin
			grnPatQ <= grnPat;
			if (grnPat != grnPatQ) grnPh <= '0;
			else if (msTick)
				grnPh <= (grnPh == periodMs(grnPat) - 1'b1) ? '0
					: grnPh + 1'b1;
		end
	end

	// a freshly selected pattern shows its lit phase at once, not a stale one
	assign redLit = redSteady ||
		litAt(redPat, (redPat != redPatQ) ? PW'(0) : redPh);
	assign grnLit = grnSteady ||
		litAt(grnPat, (grnPat != grnPatQ) ? PW'(0) : grnPh);

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			redLed <= 1'b0;
			greenLed <= 1'b0;
		end else if (!testDone) begin
			// alternate colours each 100 ms during the lamp test
			redLed <= (testMs / PW'(`LAMP_STEP_MS)) % PW'(2) == PW'(0);
			greenLed <= (testMs / PW'(`LAMP_STEP_MS)) % PW'(2) == PW'(1);
		end else begin
			redLed <= redLit;
			greenLed <= grnLit && !redOn;
		end
	end

	// apb slave, zero wait states
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			enable <= 1'b1;
			nodeId <= `NODE_RESET;
		end else if (psel && penable && pwrite) begin
			if (paddr == `REG_CTRL) enable <= pwdata[`CTRL_ENABLE_BIT];
			else if (paddr == `REG_NODE && !nodeBad)
				nodeId <= pwdata[6:0];
		end
	end
	// identifiers outside 1..127 are refused with an error
	assign nodeBad = (pwdata[6:0] < `NODE_MIN) || (pwdata[31:7] != 25'h0);

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable) begin
				if (paddr == `REG_CTRL) prdata <= {31'h0, enable};
				else if (paddr == `REG_STATUS)
					prdata <= {26'h0, testDone, pwrSync[1], redOn,
						greenLed, redLed, busOff};
				else if (paddr == `REG_NODE) prdata <= {25'h0, nodeId};
				else pslverr <= 1'b1;
				if (pwrite && paddr == `REG_NODE && nodeBad)
					pslverr <= 1'b1;
			end
		end
	end

	// assertions
	busoff_red_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		testDone && busOff && enable && pwrSync[1] |=> redLed)
		else $error("red not lit during bus-off");
	red_prio_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		testDone && redOn |=> !greenLed)
		else $error("green lit while red indicates");
	red_dark_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		testDone && !busOff && !warnLevel && !errPassive && !guardTimeout
		|=> !redLed)
		else $error("red lit with no error");
	oper_green_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		testDone && nmtState == 2'h3 && !redOn && enable && pwrSync[1]
		|=> greenLed)
		else $error("green dark while operational");
	restart_lit_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		redPat != redPatQ |=> redPh == '0)
		else $error("phase not restarted");
	single_off_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		redPat == status_led_pkg::PAT_SINGLE && redPatQ == redPat &&
		redPh >= PW'(`LIT_MS) |-> !redLit)
		else $error("single flash lit in dark phase");
	double_gap_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		redPat == status_led_pkg::PAT_DOUBLE && redPatQ == redPat &&
		redPh >= PW'(`LIT_MS) && redPh < PW'(`LIT_MS + `GAP_MS)
		|-> !redLit)
		else $error("double flash gap lit");
	double_pulse_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		redPat == status_led_pkg::PAT_DOUBLE && redPatQ == redPat &&
		redPh >= PW'(`LIT_MS + `GAP_MS) &&
		redPh < PW'(2 * `LIT_MS + `GAP_MS) |-> redLit)
		else $error("second flash not lit");
	blink_on_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		grnPat == status_led_pkg::PAT_BLINK && grnPh < PW'(`LIT_MS)
		|-> grnLit)
		else $error("blink not lit in lit phase");
	blink_dark_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		grnPat == status_led_pkg::PAT_BLINK && grnPatQ == grnPat &&
		grnPh >= PW'(`LIT_MS) |-> !grnLit)
		else $error("blink lit in dark phase");
	stop_flash_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		enable && pwrSync[1] && nmtState == 2'h1
		|-> grnPat == status_led_pkg::PAT_SINGLE)
		else $error("stopped state not single flash");
	timeout_prio_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		enable && pwrSync[1] && !busOff && guardTimeout && errCtrlStarted
		|-> redPat == status_led_pkg::PAT_DOUBLE)
		else $error("timeout not preferred over warning");
	off_dark_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		testDone && !(enable && pwrSync[1]) |=> !redLed && !greenLed)
		else $error("indicator lit while disabled or unpowered");
	node_range_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		nodeId >= `NODE_MIN)
		else $error("node id out of range");
	node_err_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		psel && !penable && pwrite && paddr == `REG_NODE && nodeBad
		|=> pslverr)
		else $error("bad node id not refused");
	node_keep_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		psel && penable && pwrite && paddr == `REG_NODE && nodeBad
		|=> $stable(nodeId))
		else $error("bad node id written");
	tick_bound_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		int'(msCnt) < MS_CYCLES)
		else $error("millisecond counter overran");
	lamp_end_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		testMs <= PW'(`LAMP_TEST_MS))
		else $error("lamp test counter overran");
	lamp_test_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		!testDone |=> !(redLed && greenLed))
		else $error("both colours lit in lamp test");

	busoff_c: cover property (@(posedge sys_clk) testDone && busOff);
	double_c: cover property (@(posedge sys_clk)
		redPat == status_led_pkg::PAT_DOUBLE && redLed);
	preop_c: cover property (@(posedge sys_clk)
		grnPat == status_led_pkg::PAT_BLINK && greenLed);
	bad_node_c: cover property (@(posedge sys_clk) pslverr);
	unpowered_c: cover property (@(posedge sys_clk)
		testDone && !pwrSync[1]);

endmodule : canopen_status_led_driver
